// ==== hdl/stb_pkg.sv ====
/*
  Shared constants and types for the byte-wide STS-3/STM-1 telecom bus port.
  Assumes one system clock; the transmit bus clock is divided from it.
*/
package stb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [15:0] FRAME_SYNC_DELAY_ADDR = 16'h0135;
  localparam logic [15:0] PARITY_CTRL_ADDR      = 16'h0137;
  localparam logic [15:0] PORT_STATUS_ADDR      = 16'h0138;

  // reset values
  localparam logic [7:0]  FRAME_SYNC_DELAY_RST  = 8'h00;
  localparam logic [7:0]  PARITY_CTRL_RST       = 8'h00;

  // status field positions (write one to clear)
  localparam int          STAT_PARITY_ERR_BIT   = 0;
  localparam int          STAT_AIS_LSB          = 1;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout, in byte times
  localparam int          FRAME_ROWS            = 9;
  localparam int          FRAME_COLS            = 270;
  localparam int          TOH_COLS              = 9;
  localparam int          A1_LAST_COL           = 2;
  localparam int          A2_LAST_COL           = 5;
  localparam int          C1_COL                = 6;
  localparam int          CHANNELS              = 3;
  localparam logic [7:0]  A1_PATTERN            = 8'hF6;
  localparam logic [7:0]  A2_PATTERN            = 8'h28;
  localparam logic [7:0]  FILL_BYTE             = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          SYS_PERIOD_PS         = 100000;
  localparam int          TXCLK_PERIOD_PS       = 51440;
  // half period of the bus clock, longest time so rounded down, at least one
  localparam int          TXCLK_HALF_CYCLES     = (TXCLK_PERIOD_PS / 2 / SYS_PERIOD_PS) < 1 ? 1 :
                                                  (TXCLK_PERIOD_PS / 2 / SYS_PERIOD_PS);

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [2:0] spare;
    logic       extAlign;
    logic       retimingBypassed;
    logic       parityWithCtl;
    logic       parityOdd;
    logic       busEnable;
  } stb_ctrl_type;

  typedef struct packed {
    logic       ais;
    logic [7:0] data;
  } stb_tx_word_type;

  typedef struct packed {
    logic [7:0] data;
    logic       payload;
    logic       marker;
    logic       parity;
    logic       alarm;
  } stb_rx_pins_type;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [15:0] addr;
    logic [7:0] wrData;
  } stb_reg_req_type;

  typedef enum logic [1:0] {
    TX_OFF   = 2'b00,
    TX_RUN   = 2'b01,
    TX_ALIGN = 2'b11
  } stb_tx_state_type;

endpackage

// ==== hdl/stb_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides; flags are registered.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module stb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
    logic          notFull;
    logic          notEmpty;
  } stb_fifo_state_type;

  stb_fifo_state_type state;
  stb_fifo_state_type next_state;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  ////////////////////////////////////////////////////////////////////////////
  assign push     = inValid & state.notFull;
  assign pop      = outReady & state.notEmpty;
  assign inReady  = state.notFull;
  assign outValid = state.notEmpty;
  assign outData  = mem[state.rdPtr];

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wrPtr = (state.wrPtr == AW'(DEPTH - 1)) ? '0 : state.wrPtr + 1'b1;
    end
    if (pop) begin
      next_state.rdPtr = (state.rdPtr == AW'(DEPTH - 1)) ? '0 : state.rdPtr + 1'b1;
    end
    next_state.count    = state.count + (AW+1)'(push) - (AW+1)'(pop);
    next_state.notFull  = next_state.count != (AW+1)'(DEPTH);
    next_state.notEmpty = next_state.count != '0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state          <= '0;
      state.notFull  <= 1'b1;
    end else begin
      state <= next_state;
    end
    if (push) begin
      mem[state.wrPtr] <= inData;
    end
  end

endmodule

// ==== hdl/stb_bus_port.sv ====
/*
  Telecom bus port: transmit framer driving the byte bus with payload
  indicator, phase marker, path alarm flag and parity, plus the receive
  sampler with parity check and per-channel path alarm declaration.
  Assumes clk_sys at 10 MHz, far-end logic on the pins, a simple register
  port from the local processor, and a payload source behind the FIFO.
*/
// Summary of operation
// - transmit alarm flag high exactly on bytes of channels carrying path AIS
// - transmit alarm flag only active when bus enabled and retiming bypassed
// - transmit parity even or odd, over data or data plus indicator and marker
// - with external alignment on, a sync rising edge starts a new frame
// - sync input held low means free-running frames
// - frame start delayed by the frame-sync delay register after the sync edge
// - transmit payload indicator low on overhead bytes, high on payload bytes
// - enabled bus sends one byte per bus clock, changing on its rising edge
// - receive inputs sampled on falling edge of external receive bus clock
// - receive side checks configured parity on every byte while the bus is enabled
// - receive alarm pulse declares path AIS for that channel
// - transmit bus clock generated internally, outputs update on its rising edge
// - phase marker pulses on C1 with indicator low and J1 with indicator high
`timescale 1ns/10ps
module stb_bus_port
  import stb_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int J1_ROW     = 0,
  parameter int J1_COL     = 9
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // register port
  input  wire stb_pkg::stb_reg_req_type regReq,
  output logic [7:0]                    regRdData,
  // transmit payload source
  input  wire logic                     txInValid,
  input  wire stb_pkg::stb_tx_word_type txInWord,
  output logic                          txInReady,
  // transmit bus pins
  output logic                          tx_bus_clock,
  output logic [7:0]                    tx_bus_byte,
  output logic                          tx_payload_ind,
  output logic                          tx_phase_marker,
  output logic                          tx_path_ais_flag,
  output logic                          tx_parity_out,
  input  wire logic                     tx_frame_sync_in,
  // receive bus pins
  input  wire logic                     rx_bus_clock,
  input  wire stb_pkg::stb_rx_pins_type rx_bus_pins,
  // status
  output logic                          rxParityErr,
  output logic [CHANNELS-1:0]           rxPathAis
);

  localparam int DIV_W = $clog2(TXCLK_HALF_CYCLES + 1);

  typedef struct packed {
    stb_ctrl_type        ctrl;
    logic [7:0]          syncDelay;
    logic [7:0]          rdData;
    logic                parityErr;
    logic [CHANNELS-1:0] pathAis;
    stb_tx_state_type    txState;
    logic [7:0]          alignCnt;
    logic [DIV_W-1:0]    divCnt;
    logic                txClk;
    logic [8:0]          col;
    logic [3:0]          row;
    logic [7:0]          txByte;
    logic                txPl;
    logic                txMarker;
    logic                txAis;
    logic                txParity;
    logic [2:0]          syncSync;
    logic [2:0]          rxClkSync;
    stb_rx_pins_type     rxPinsMeta;
    stb_rx_pins_type     rxPins;
    logic [1:0]          rxChan;
  } stb_port_state_type;

  stb_port_state_type state;
  stb_port_state_type next_state;
  logic               fifoValid;
  stb_tx_word_type    fifoWord;
  logic               fifoPop;
  logic               fifoReady;

  ////////////////////////////////////////////////////////////////////////////
  // parity over data, optionally with indicator and marker
  function automatic logic calcParity(input logic [7:0] data, input logic pl, input logic mk,
                                      input stb_ctrl_type ctrl);
    logic ones;
    ones = ^data;
    if (ctrl.parityWithCtl) begin
      ones = ones ^ pl ^ mk;
    end
    return ones ^ ctrl.parityOdd;
  endfunction

  // next frame position, wrapping at the end of the frame
  function automatic logic [12:0] stepPos(input logic [8:0] col, input logic [3:0] row);
    logic [8:0] nCol;
    logic [3:0] nRow;
    nCol = col + 9'd1;
    nRow = row;
    if (col == 9'(FRAME_COLS - 1)) begin
      nCol = '0;
      nRow = (row == 4'(FRAME_ROWS - 1)) ? 4'd0 : row + 4'd1;
    end
    return {nRow, nCol};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // payload buffer; the framer drains it only on payload byte times
  stb_fifo #(
    .WIDTH ($bits(stb_tx_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inValid  (txInValid),
    .inData   (txInWord),
    .inReady  (fifoReady),
    .outValid (fifoValid),
    .outData  (fifoWord),
    .outReady (fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic        byteStep;
  logic        syncRise;
  logic        rxFall;
  logic [12:0] pos;
  logic        isPayload;
  logic        rxParityExp;
  logic        busOn;
  logic        txLive;

  always_comb begin
    next_state = state;
    busOn      = state.ctrl.busEnable;
    // the enabling step sends fill, so column 0 of the first frame goes out once
    txLive     = busOn && (state.txState != TX_OFF);
    byteStep   = 1'b0;
    pos        = stepPos(state.col, state.row);
    isPayload  = 1'b0;
    fifoPop    = 1'b0;

    // register port; status clear loses to a same-cycle set below
    next_state.rdData = '0;
    if (regReq.read) begin
      unique case (regReq.addr)
        FRAME_SYNC_DELAY_ADDR: next_state.rdData = state.syncDelay;
        PARITY_CTRL_ADDR:      next_state.rdData = state.ctrl;
        PORT_STATUS_ADDR:      next_state.rdData = 8'({state.pathAis, state.parityErr});
        default:               next_state.rdData = '0;
      endcase
    end
    if (regReq.write) begin
      unique case (regReq.addr)
        FRAME_SYNC_DELAY_ADDR: next_state.syncDelay = regReq.wrData;
        PARITY_CTRL_ADDR:      next_state.ctrl      = regReq.wrData;
        PORT_STATUS_ADDR: begin
          if (regReq.wrData[STAT_PARITY_ERR_BIT]) begin
            next_state.parityErr = 1'b0;
          end
          next_state.pathAis = state.pathAis & ~regReq.wrData[STAT_AIS_LSB +: CHANNELS];
        end
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // transmit bus clock divided from the system clock
    next_state.divCnt = state.divCnt + 1'b1;
    if (state.divCnt == DIV_W'(TXCLK_HALF_CYCLES - 1)) begin
      next_state.divCnt = '0;
      next_state.txClk  = ~state.txClk;
      byteStep          = ~state.txClk;
    end

    // frame sync edge; the pin passes two flops before the edge is taken
    next_state.syncSync = {state.syncSync[1:0], tx_frame_sync_in};
    syncRise = state.syncSync[1] & ~state.syncSync[2];

    unique case (state.txState)
      TX_OFF: begin
        if (busOn) begin
          next_state.txState = TX_RUN;
          next_state.col     = '0;
          next_state.row     = '0;
        end
      end
      TX_RUN: begin
        if (byteStep) begin
          {next_state.row, next_state.col} = pos;
        end
        if (syncRise && state.ctrl.extAlign) begin
          next_state.txState  = TX_ALIGN;
          next_state.alignCnt = state.syncDelay;
        end
      end
      TX_ALIGN: begin
        if (byteStep) begin
          {next_state.row, next_state.col} = pos;
          if (state.alignCnt == '0) begin
            next_state.row     = '0;
            next_state.col     = '0;
            next_state.txState = TX_RUN;
          end else begin
            next_state.alignCnt = state.alignCnt - 8'd1;
          end
        end
      end
      default: next_state.txState = TX_OFF;
    endcase
    if (!busOn) begin
      next_state.txState = TX_OFF;
    end

    // byte presented at this rising edge of the bus clock
    if (byteStep) begin
      isPayload           = state.col >= 9'(TOH_COLS);
      next_state.txPl     = txLive & isPayload;
      next_state.txMarker = txLive & (isPayload ? (state.row == 4'(J1_ROW) && state.col == 9'(J1_COL))
                                               : (state.row == 4'd0 && state.col == 9'(C1_COL)));
      next_state.txAis    = 1'b0;
      if (!txLive) begin
        next_state.txByte = FILL_BYTE;
      end else if (isPayload) begin
        fifoPop           = fifoValid;
        next_state.txByte = fifoValid ? fifoWord.data : FILL_BYTE;
        next_state.txAis  = fifoValid & fifoWord.ais & state.ctrl.retimingBypassed;
      end else if (state.row == 4'd0 && state.col <= 9'(A1_LAST_COL)) begin
        next_state.txByte = A1_PATTERN;
      end else if (state.row == 4'd0 && state.col <= 9'(A2_LAST_COL)) begin
        next_state.txByte = A2_PATTERN;
      end else begin
        next_state.txByte = FILL_BYTE;
      end
      next_state.txParity = calcParity(next_state.txByte, next_state.txPl,
                                       next_state.txMarker, state.ctrl);
    end

    //////////////////////////////////////////////////////////////////////////
    // receive side: clock and pins through two flops, act on the falling edge
    next_state.rxClkSync  = {state.rxClkSync[1:0], rx_bus_clock};
    next_state.rxPinsMeta = rx_bus_pins;
    next_state.rxPins     = state.rxPinsMeta;
    rxFall      = state.rxClkSync[2] & ~state.rxClkSync[1];
    rxParityExp = calcParity(state.rxPins.data, state.rxPins.payload,
                             state.rxPins.marker, state.ctrl);
    if (rxFall && busOn) begin
      if (state.rxPins.marker && !state.rxPins.payload) begin
        next_state.rxChan = 2'd1;
      end else begin
        next_state.rxChan = (state.rxChan == 2'(CHANNELS - 1)) ? 2'd0 : state.rxChan + 2'd1;
      end
      if (rxParityExp != state.rxPins.parity) begin
        next_state.parityErr = 1'b1;
      end
      if (state.rxPins.alarm) begin
        next_state.pathAis[state.rxPins.marker && !state.rxPins.payload ? 2'd0 : state.rxChan] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state           <= '0;
      state.ctrl      <= PARITY_CTRL_RST;
      state.syncDelay <= FRAME_SYNC_DELAY_RST;
      state.txState   <= TX_OFF;
    end else begin
      state <= next_state;
    end
  end

  // fifo ready is the fifo's own registered flag
  assign txInReady        = fifoReady;
  assign regRdData        = state.rdData;
  assign tx_bus_clock     = state.txClk;
  assign tx_bus_byte      = state.txByte;
  assign tx_payload_ind   = state.txPl;
  assign tx_phase_marker  = state.txMarker;
  assign tx_path_ais_flag = state.txAis;
  assign tx_parity_out    = state.txParity;
  assign rxParityErr      = state.parityErr;
  assign rxPathAis        = state.pathAis;

endmodule

// ==== dv/stb_bus_port_assertions.sv ====
/* Checker of the telecom bus port pins.
   Assumes a bind to stb_bus_port; control is shadowed from writes. */
`timescale 1ns/10ps
module stb_bus_port_checker
  import stb_pkg::*;
(
  // clock and reset
  input wire logic                         clk_sys,
  input wire logic                         rst_n,
  // register port
  input wire stb_pkg::stb_reg_req_type     regReq,
  input wire logic [7:0]                   regRdData,
  // transmit bus
  input wire logic                         tx_bus_clock,
  input wire logic [7:0]                   tx_bus_byte,
  input wire logic                         tx_payload_ind,
  input wire logic                         tx_phase_marker,
  input wire logic                         tx_path_ais_flag,
  input wire logic                         tx_parity_out,
  // status
  input wire logic                         rxParityErr,
  input wire logic [stb_pkg::CHANNELS-1:0] rxPathAis
);
  stb_ctrl_type ctrl;
  logic [2:0]   quiet;
  logic         ctrlWr;
  logic         statClr;
  logic         errClr;
  assign ctrlWr = regReq.write && regReq.addr == PARITY_CTRL_ADDR;
  assign statClr = regReq.write && regReq.addr == PORT_STATUS_ADDR;
  assign errClr = statClr && regReq.wrData[STAT_PARITY_ERR_BIT];
  // settling after a control write is not judged
  always_ff @(posedge clk_sys) begin
    if (!rst_n || ctrlWr) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
    if (!rst_n) begin
      ctrl <= stb_ctrl_type'(PARITY_CTRL_RST);
    end else if (ctrlWr) begin
      ctrl <= stb_ctrl_type'(regReq.wrData);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  parity_out_a: assert property (
    quiet == 3'h7 |-> tx_parity_out == (^tx_bus_byte ^ ctrl.parityOdd
      ^ (ctrl.parityWithCtl & (tx_payload_ind ^ tx_phase_marker))))
    else $error("parity out wrong");
  alarm_gate_a: assert property (
    tx_path_ais_flag && quiet == 3'h7 |-> ctrl.busEnable && ctrl.retimingBypassed && tx_payload_ind)
    else $error("alarm flag not allowed here");
  byte_hold_a: assert property (
    tx_bus_clock && ctrl.busEnable && quiet == 3'h7 |=> $stable({tx_bus_byte, tx_payload_ind, tx_phase_marker}))
    else $error("byte changed off the rising bus clock");
  clock_toggle_a: assert property (
    $past(rst_n) |-> tx_bus_clock != $past(tx_bus_clock))
    else $error("bus clock stuck");
  c1_then_j1_a: assert property (
    tx_bus_clock && tx_phase_marker && !tx_payload_ind && ctrl.busEnable |->
      ##2 !(tx_payload_ind || tx_phase_marker) ##2 !(tx_payload_ind || tx_phase_marker)
      ##2 tx_payload_ind && tx_phase_marker)
    else $error("marker sequence wrong");
  read_ctrl_a: assert property (
    regReq.read && !regReq.write && regReq.addr == PARITY_CTRL_ADDR |=> regRdData == ctrl)
    else $error("control readback wrong");
  err_sticky_a: assert property (
    $past(rst_n) && $fell(rxParityErr) |-> $past(errClr))
    else $error("parity error lost");
  ais_sticky_a: assert property (
    $past(rst_n) && |($past(rxPathAis) & ~rxPathAis) |-> $past(statClr))
    else $error("path alarm lost");
endmodule

bind stb_bus_port stb_bus_port_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq),
  .regRdData(regRdData), .tx_bus_clock(tx_bus_clock), .tx_bus_byte(tx_bus_byte),
  .tx_payload_ind(tx_payload_ind), .tx_phase_marker(tx_phase_marker), .tx_path_ais_flag(tx_path_ais_flag),
  .tx_parity_out(tx_parity_out), .rxParityErr(rxParityErr), .rxPathAis(rxPathAis));

// ==== dv/stb_far_end.sv ====
/* Far-end framer model: receive bus and frame sync pin.
   Assumes the bench calls its tasks; clk_sys is the reference. */
`timescale 1ns/10ps
module stb_far_end
  import stb_pkg::*;
(
  // reference clock
  input wire logic                 clk_sys,
  // pins toward the port
  output logic                     rx_bus_clock,
  output stb_pkg::stb_rx_pins_type rx_bus_pins,
  output logic                     tx_frame_sync_in
);
  initial begin
    rx_bus_clock = 1'b1;
    rx_bus_pins = '0;
    tx_frame_sync_in = 1'b0;
  end
  // slow bus clock: the port needs several reference cycles per edge
  task automatic sendByte(input logic [7:0] d, input logic pl, mk, al, bad, wc, odd);
    stb_rx_pins_type p;
    p = '{data: d, payload: pl, marker: mk, alarm: al,
          parity: ^d ^ (wc & (pl ^ mk)) ^ odd ^ bad};
    @(posedge clk_sys);
    rx_bus_pins <= p;
    repeat (4) @(posedge clk_sys);
    rx_bus_clock <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rx_bus_clock <= 1'b1;
    // released data must not look valid; flags fall back low
    rx_bus_pins <= '{data: ~d, parity: ~p.parity, default: 1'b0};
  endtask
  task automatic syncPulse();
    @(posedge clk_sys);
    tx_frame_sync_in <= 1'b1;
    @(posedge clk_sys);
    tx_frame_sync_in <= 1'b0;
  endtask
endmodule

// ==== dv/test_stb_bus_port.sv ====
/* Bench of the telecom bus port.
   Assumes the far-end model on the pins and the bound checker. */
`timescale 1ns/10ps
module test_stb_bus_port;
  import stb_pkg::*;
  logic                clk_sys = 1'b0;
  logic                rst_n = 1'b0;
  stb_reg_req_type     regReq = '0;
  logic                txInValid = 1'b0;
  stb_tx_word_type     txInWord = '0;
  logic [7:0]          regRdData, txByte, b;
  logic                txInReady, txClk, txPl, txMk, txAis, txPar, rxClk, syncIn, rxParityErr, pl, mk, ais, r;
  stb_rx_pins_type     rxPins;
  logic [CHANNELS-1:0] rxPathAis;
  int                  fail_count = 0;
  int                  checked = 0;
  int                  n, n0;
  stb_bus_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
    .txInValid(txInValid), .txInWord(txInWord), .txInReady(txInReady), .tx_bus_clock(txClk),
    .tx_bus_byte(txByte), .tx_payload_ind(txPl), .tx_phase_marker(txMk), .tx_path_ais_flag(txAis),
    .tx_parity_out(txPar), .tx_frame_sync_in(syncIn), .rx_bus_clock(rxClk), .rx_bus_pins(rxPins),
    .rxParityErr(rxParityErr), .rxPathAis(rxPathAis));
  stb_far_end farEnd (.clk_sys(clk_sys), .rx_bus_clock(rxClk), .rx_bus_pins(rxPins), .tx_frame_sync_in(syncIn));
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic expPar(input logic [7:0] d, input logic p, m, wc, odd);
    return ^d ^ (wc & (p ^ m)) ^ odd;
  endfunction
  task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wrData: d};
    @(posedge clk_sys);
    regReq.write <= 1'b0;
  endtask
  task automatic regRead(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk_sys);
    regReq.read <= 1'b0;
    #1 check(16'(regRdData), 16'(exp));
  endtask
  // the bus clock toggles every cycle, so high after an edge means a byte time
  task automatic byteTime();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      #1;
      if (txClk === 1'b1) return;
    end
    fail_count++;
    end_of_test();
  endtask
  task automatic findA1(output int cnt);
    cnt = 0;
    #1;
    while (txByte !== A1_PATTERN) begin
      byteTime();
      cnt++;
      if (cnt > 3000) begin
        fail_count++;
        end_of_test();
      end
    end
  endtask
  task automatic syncMeasure(input logic [7:0] d, output int cnt);
    regWrite(FRAME_SYNC_DELAY_ADDR, d);
    findA1(cnt);
    repeat (1000) byteTime();
    farEnd.syncPulse();
    findA1(cnt);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    regRead(FRAME_SYNC_DELAY_ADDR, FRAME_SYNC_DELAY_RST);
    regRead(PARITY_CTRL_ADDR, PARITY_CTRL_RST);
    regWrite(16'h0136, 8'hA5);
    regRead(16'h0136, 8'h00);
    regWrite(FRAME_SYNC_DELAY_ADDR, 8'h5A);
    regRead(FRAME_SYNC_DELAY_ADDR, 8'h5A);
    // receive side ignored while disabled
    farEnd.sendByte(8'h01, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clk_sys);
    check(16'({rxPathAis, rxParityErr}), 16'h0000);
    regWrite(PARITY_CTRL_ADDR, 8'h07);
    farEnd.sendByte(8'h5C, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    farEnd.sendByte(8'h11, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    farEnd.sendByte(8'hE3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge clk_sys);
    check(16'({rxPathAis, rxParityErr}), 16'h0004);
    farEnd.sendByte(8'h22, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    repeat (6) @(posedge clk_sys);
    check(16'(rxParityErr), 16'h0001);
    regRead(PORT_STATUS_ADDR, 8'h05);
    regWrite(PORT_STATUS_ADDR, 8'h0F);
    regRead(PORT_STATUS_ADDR, 8'h00);
    // fill the buffer while the bus is off, until it refuses
    regWrite(PARITY_CTRL_ADDR, 8'h00);
    n = 0;
    txInValid <= 1'b1;
    txInWord <= '{ais: 1'b0, data: 8'h40};
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys) r = txInReady;
      @(posedge clk_sys);
      if (r) begin
        n++;
        txInWord <= '{ais: n[0], data: 8'h40 + n[7:0]};
      end
    end
    txInValid <= 1'b0;
    check({15'h0000, txInReady} | 16'(n << 1), 16'h0040);
    // enable with bypass: first 46 bytes of the new frame
    regWrite(PARITY_CTRL_ADDR, 8'h09);
    findA1(n);
    for (int c = 0; c < 46; c++) begin
      b = c <= A1_LAST_COL ? A1_PATTERN : c <= A2_LAST_COL ? A2_PATTERN : FILL_BYTE;
      pl = c >= TOH_COLS;
      mk = c == C1_COL || c == 9;
      ais = 1'b0;
      if (pl && c < TOH_COLS + 32) begin
        b = 8'h40 + 8'(c - TOH_COLS);
        ais = b[0];
      end
      check(16'({txByte, txPl, txMk, txAis, txPar}),
            16'({b, pl, mk, ais, expPar(b, pl, mk, 1'b0, 1'b0)}));
      byteTime();
    end
    check(16'(txInReady), 16'h0001);
    // every parity mode, bypass off: alarm must stay low
    for (int m = 0; m < 4; m++) begin
      regWrite(PARITY_CTRL_ADDR, 8'h01 | 8'(m << 1));
      txInValid <= 1'b1;
      txInWord <= '{ais: 1'b1, data: 8'h31};
      @(posedge clk_sys);
      txInValid <= 1'b0;
      // the marked word leaves within the checked bytes, so the gate is really tried
      for (int k = 0; k < 300; k++) begin
        byteTime();
        check(16'({txAis, txPar}), 16'({1'b0, expPar(txByte, txPl, txMk, m[1], m[0])}));
      end
    end
    // external alignment with two delays, then free running
    regWrite(PARITY_CTRL_ADDR, 8'h11);
    syncMeasure(8'h00, n0);
    syncMeasure(8'h05, n);
    check(16'(n - n0), 16'h0005);
    check(16'(n0 < 10), 16'h0001);
    repeat (3) byteTime();
    findA1(n);
    check(16'(n + 3), 16'(FRAME_ROWS * FRAME_COLS));
    end_of_test();
  end
endmodule
